// *** common/rdt_pkg.sv ***
// Constants and types shared by the down timer design
// Notes on behaviour
// - Down count reaching zero raises interrupt
// - Up count reaching full scale raises interrupt
// - Any write to irq_clear clears pending interrupt
// - Time word: hours, minutes, seconds, 1/128 fields
// - Time layout applies to load and count
// - Sixteen-bit counter counting down from load
// - Prescale codes 1, 16, 256; 11 acts 00
// - Terminal count drives conversion start output
// - Load register read/write, resets zero
// - Live count read-only, resets all ones
// - Control bit 7 enables counting, reset off
// - Control bit 6 periodic, else free-running
package rdt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] RDT_ADDR_RELOAD  = 32'hffff_0300;
  localparam logic [31:0] RDT_ADDR_LIVE    = 32'hffff_0304;
  localparam logic [31:0] RDT_ADDR_CTRL    = 32'hffff_0308;
  localparam logic [31:0] RDT_ADDR_CLR     = 32'hffff_030c;
  localparam logic [31:0] RDT_ADDR_STATUS  = 32'hffff_0310;
  localparam logic [31:0] RDT_ADDR_MASK    = 32'hffff_0314;
  localparam logic [31:0] RDT_ADDR_DIR     = 32'hffff_0318;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RDT_RST_RELOAD   = 32'h0000_0000;
  localparam logic [31:0] RDT_RST_LIVE     = 32'h0000_ffff;
  localparam logic [15:0] RDT_RST_CTRL     = 16'h0000;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int          RDT_CTRL_EN      = 7;
  localparam int          RDT_CTRL_PER     = 6;
  localparam int          RDT_FMT_HI       = 5;
  localparam int          RDT_FMT_LO       = 4;
  localparam int          RDT_PRE_HI       = 3;
  localparam int          RDT_PRE_LO       = 2;
  localparam logic [15:0] RDT_CTRL_WMASK   = 16'h00fc;
  localparam logic [1:0]  RDT_FMT_TOD      = 2'b10;

  // ****************************************
  // Prescaler
  // ****************************************
  localparam logic [1:0]  RDT_PRE_DIV1     = 2'b00;
  localparam logic [1:0]  RDT_PRE_DIV16    = 2'b01;
  localparam logic [1:0]  RDT_PRE_DIV256   = 2'b10;
  localparam logic [7:0]  RDT_DIV16_LAST   = 8'h0f;
  localparam logic [7:0]  RDT_DIV256_LAST  = 8'hff;

  // ****************************************
  // Time-of-day layout
  // ****************************************
  localparam logic [31:0] RDT_TOD_MASK     = 32'hff3f_3f7f;
  localparam logic [31:0] RDT_TOD_FULL     = 32'hff3b_3b7f;
  localparam logic [5:0]  RDT_TOD_SEC_MAX  = 6'h3b;
  localparam logic [6:0]  RDT_TOD_FRAC_MAX = 7'h7f;
  localparam logic [15:0] RDT_BIN_FULL     = 16'hffff;

  typedef enum logic [1:0] {
    RDT_APB_IDLE = 2'b01,
    RDT_APB_ACK  = 2'b10
  } rdt_apb_e;

endpackage

// *** core/rdt_prescale.sv ***
// Core clock prescaler producing one-cycle count ticks
`timescale 1ns/1ps
`default_nettype none
module rdt_prescale
  import rdt_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // Tick
  output logic            tick
);

  logic [7:0] cnt_q;
  logic [7:0] last;

  always_comb begin
    case (sel)
      RDT_PRE_DIV16:  last = RDT_DIV16_LAST;
      RDT_PRE_DIV256: last = RDT_DIV256_LAST;
      default:        last = 8'h00;
    endcase
  end

  // Held at zero while stopped so a restart gives a full first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (!run || cnt_q >= last) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign tick = run && (cnt_q >= last);

endmodule
`default_nettype wire

// *** core/rdt_tod_step.sv ***
// One step of the time-of-day word, up or down with carry
`timescale 1ns/1ps
`default_nettype none
module rdt_tod_step
  import rdt_pkg::*;
(
  // Word in and direction
  input  wire logic [31:0] cur,
  input  wire logic        up,
  // Stepped word
  output logic [31:0]      nxt
);

  logic [7:0] hr;
  logic [5:0] mn;
  logic [5:0] sc;
  logic [6:0] fr;

  always_comb begin
    hr = cur[31:24];
    mn = cur[21:16];
    sc = cur[13:8];
    fr = cur[6:0];
    if (up) begin
      if (fr != RDT_TOD_FRAC_MAX) begin
        fr = fr + 7'h01;
      end else begin
        fr = 7'h00;
        if (sc < RDT_TOD_SEC_MAX) begin
          sc = sc + 6'h01;
        end else begin
          sc = 6'h00;
          if (mn < RDT_TOD_SEC_MAX) begin
            mn = mn + 6'h01;
          end else begin
            mn = 6'h00;
            hr = hr + 8'h01;
          end
        end
      end
    end else begin
      if (fr != 7'h00) begin
        fr = fr - 7'h01;
      end else begin
        fr = RDT_TOD_FRAC_MAX;
        if (sc != 6'h00) begin
          sc = sc - 6'h01;
        end else begin
          sc = RDT_TOD_SEC_MAX;
          if (mn != 6'h00) begin
            mn = mn - 6'h01;
          end else begin
            mn = RDT_TOD_SEC_MAX;
            hr = hr - 8'h01;
          end
        end
      end
    end
    nxt = {hr, 2'b00, mn, 2'b00, sc, 1'b0, fr};
  end

endmodule
`default_nettype wire

// *** core/rdt_timer.sv ***
// Down timer top: APB registers, counter, interrupt, trigger
`timescale 1ns/1ps
`default_nettype none
module rdt_timer
  import rdt_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Events
  output logic             irq,
  output logic             adc_start
);

  // ****************************************
  // State
  // ****************************************
  rdt_apb_e    apb_q;
  logic [31:0] reload_value_q;
  logic [31:0] live_count_q;
  logic [31:0] live_count_d;
  logic [15:0] timer_control_q;
  logic        status_q;
  logic        mask_q;
  logic        dir_up_q;
  logic [31:0] prdata_q;
  logic        slverr_q;
  logic        adc_start_q;

  // ****************************************
  // Decode
  // ****************************************
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        hit_reload;
  logic        hit_live;
  logic        hit_ctrl;
  logic        hit_clr;
  logic        hit_status;
  logic        hit_mask;
  logic        hit_dir;
  logic        mapped;

  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign hit_reload = (paddr == RDT_ADDR_RELOAD);
  assign hit_live   = (paddr == RDT_ADDR_LIVE);
  assign hit_ctrl   = (paddr == RDT_ADDR_CTRL);
  assign hit_clr    = (paddr == RDT_ADDR_CLR);
  assign hit_status = (paddr == RDT_ADDR_STATUS);
  assign hit_mask   = (paddr == RDT_ADDR_MASK);
  assign hit_dir    = (paddr == RDT_ADDR_DIR);
  assign mapped     = hit_reload || hit_live || hit_ctrl || hit_clr
                   || hit_status || hit_mask || hit_dir;

  // Writes take effect only on the access edge that sees pready
  assign wr_en = access && pready && pwrite && !pslverr;

  // ****************************************
  // Control fields
  // ****************************************
  logic       enabled;
  logic       periodic;
  logic       tod_fmt;
  logic [1:0] pre_sel;

  assign enabled  = timer_control_q[RDT_CTRL_EN];
  assign periodic = timer_control_q[RDT_CTRL_PER];
  assign tod_fmt  = (timer_control_q[RDT_FMT_HI:RDT_FMT_LO]
                     == RDT_FMT_TOD);
  assign pre_sel  = timer_control_q[RDT_PRE_HI:RDT_PRE_LO];

  // ****************************************
  // APB handshake
  // ****************************************
  // Read data is captured in the setup cycle so prdata comes from
  // a flip-flop and the access phase still needs no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_q <= RDT_APB_IDLE;
    end else begin
      case (apb_q)
        RDT_APB_IDLE: begin
          if (setup) begin
            apb_q <= RDT_APB_ACK;
          end
        end
        RDT_APB_ACK: begin
          if (access) begin
            apb_q <= RDT_APB_IDLE;
          end else if (!psel) begin
            apb_q <= RDT_APB_IDLE;
          end
        end
        default: begin
          apb_q <= RDT_APB_IDLE;
        end
      endcase
    end
  end

  assign pready  = access && (apb_q == RDT_APB_ACK);
  assign pslverr = pready && slverr_q;
  assign prdata  = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= !mapped || (!pwrite && hit_clr)
                 || (pwrite && hit_live);
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_reload) begin
      rd_mux = tod_fmt ? reload_value_q
                       : {16'h0000, reload_value_q[15:0]};
    end else if (hit_live) begin
      rd_mux = tod_fmt ? live_count_q
                       : {16'h0000, live_count_q[15:0]};
    end else if (hit_ctrl) begin
      rd_mux = {16'h0000, timer_control_q & RDT_CTRL_WMASK};
    end else if (hit_status) begin
      rd_mux = {31'h0000_0000, status_q};
    end else if (hit_mask) begin
      rd_mux = {31'h0000_0000, mask_q};
    end else if (hit_dir) begin
      rd_mux = {31'h0000_0000, dir_up_q};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= (pwrite) ? 32'h0000_0000 : rd_mux;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Byte strobes are honoured on the stored registers; the clear
  // register reacts to any write at all.
  logic [31:0] wr_bytes;

  always_comb begin
    wr_bytes = {{8{pstrb[3]}}, {8{pstrb[2]}},
                {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value_q <= RDT_RST_RELOAD;
    end else if (wr_en && hit_reload) begin
      if (tod_fmt) begin
        reload_value_q <= ((pwdata & wr_bytes)
                          | (reload_value_q & ~wr_bytes))
                          & RDT_TOD_MASK;
      end else begin
        reload_value_q <= {16'h0000,
                           (pwdata[15:0] & wr_bytes[15:0])
                           | (reload_value_q[15:0]
                              & ~wr_bytes[15:0])};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_q <= RDT_RST_CTRL;
    end else if (wr_en && hit_ctrl && pstrb[0]) begin
      timer_control_q <= pwdata[15:0] & RDT_CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 1'b0;
    end else if (wr_en && hit_mask && pstrb[0]) begin
      mask_q <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_up_q <= 1'b0;
    end else if (wr_en && hit_dir && pstrb[0]) begin
      dir_up_q <= pwdata[0];
    end
  end

  // ****************************************
  // Prescaler and step logic
  // ****************************************
  logic        tick;
  logic [31:0] tod_next;
  logic [31:0] step;
  logic [31:0] term;
  logic [31:0] reload_fmt;

  rdt_prescale u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enabled),
    .sel     (pre_sel),
    .tick    (tick)
  );

  rdt_tod_step u_tod_step (
    .cur (live_count_q),
    .up  (dir_up_q),
    .nxt (tod_next)
  );

  always_comb begin
    if (tod_fmt) begin
      step       = tod_next;
      term       = dir_up_q ? RDT_TOD_FULL : 32'h0000_0000;
      reload_fmt = reload_value_q & RDT_TOD_MASK;
    end else if (dir_up_q) begin
      step       = {16'h0000, live_count_q[15:0] + 16'h0001};
      term       = {16'h0000, RDT_BIN_FULL};
      reload_fmt = {16'h0000, reload_value_q[15:0]};
    end else begin
      step       = {16'h0000, live_count_q[15:0] - 16'h0001};
      term       = 32'h0000_0000;
      reload_fmt = {16'h0000, reload_value_q[15:0]};
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  // A load write also restarts the count from the new value, but not the
  // prescaler, so the first period is exact only with prescale code 00 or 11.
  logic at_term;
  logic hit_term;

  assign at_term = (live_count_q == term);

  always_comb begin
    live_count_d = live_count_q;
    if (wr_en && hit_reload) begin
      if (tod_fmt) begin
        live_count_d = ((pwdata & wr_bytes)
                       | (reload_value_q & ~wr_bytes))
                       & RDT_TOD_MASK;
      end else begin
        live_count_d = {16'h0000,
                        (pwdata[15:0] & wr_bytes[15:0])
                        | (reload_value_q[15:0]
                           & ~wr_bytes[15:0])};
      end
    end else if (tick) begin
      if (periodic && at_term) begin
        live_count_d = reload_fmt;
      end else begin
        live_count_d = step;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_count_q <= RDT_RST_LIVE;
    end else begin
      live_count_q <= live_count_d;
    end
  end

  // Event fires on the tick that lands on the terminal value
  assign hit_term = tick && !(wr_en && hit_reload)
                 && (live_count_d == term);

  // ****************************************
  // Interrupt
  // ****************************************
  logic clr_req;

  assign clr_req = wr_en && ((hit_clr)
                 || (hit_status && pstrb[0] && pwdata[0]));

  // A terminal event in the clearing cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 1'b0;
    end else if (hit_term) begin
      status_q <= 1'b1;
    end else if (clr_req) begin
      status_q <= 1'b0;
    end
  end

  // Clear takes effect on the next edge, so a read of the status
  // right after the clear write already shows it low.
  assign irq = status_q && mask_q;

  // ****************************************
  // Conversion trigger
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_start_q <= 1'b0;
    end else begin
      adc_start_q <= hit_term;
    end
  end

  assign adc_start = adc_start_q;

endmodule
`default_nettype wire

// *** testbench/rdt_timer_asserts.sv ***
// Port-level concurrent checks for the down timer
`timescale 1ns/1ps
`default_nettype none
module rdt_timer_asserts
  import rdt_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events
  input wire logic        irq,
  input wire logic        adc_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire acc = psel && penable;
  wire hit = paddr inside {RDT_ADDR_RELOAD, RDT_ADDR_LIVE, RDT_ADDR_CTRL, RDT_ADDR_CLR,
                           RDT_ADDR_STATUS, RDT_ADDR_MASK, RDT_ADDR_DIR};

  sequence s_rd_done;
    acc && !pwrite;
  endsequence
  sequence s_clr;
    acc && pwrite && paddr == RDT_ADDR_CLR;
  endsequence

  a_ready_access: assert property (acc |-> pready) else $error("no ready in access");
  a_setup_quiet: assert property (psel && !penable |-> !pready) else $error("ready in setup");
  a_rdata_hold: assert property (s_rd_done ##1 !psel |-> $stable(prdata))
    else $error("read data moved while idle");
  a_bad_addr: assert property (acc && !hit |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_live_ro: assert property (acc && pwrite && paddr == RDT_ADDR_LIVE |-> pslverr)
    else $error("live count write not refused");
  a_clr_wo: assert property (acc && !pwrite && paddr == RDT_ADDR_CLR |-> pslverr)
    else $error("clear register read not refused");
  a_reload_ok: assert property (acc && paddr == RDT_ADDR_RELOAD |-> !pslverr)
    else $error("load register access refused");
  a_wr_rdata: assert property (acc && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data not zero on write");
  // A terminal event at the clearing edge may legally set the flag again
  a_clr_irq: assert property (s_clr |=> !irq or (##[0:1] adc_start))
    else $error("interrupt survived clear");
endmodule
bind rdt_timer rdt_timer_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .adc_start(adc_start));
`default_nettype wire

// *** testbench/rdt_timer_tb_top.sv ***
// Self-checking register-level bench for the down timer
`timescale 1ns/1ps
`default_nettype none
module rdt_timer_tb_top
  import rdt_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        adc_start;
  logic [31:0] r;
  logic        e;
  int          n;
  int          miscompares;
  int          comparisons;
  int          exp_gap[4] = '{3, 48, 768, 3};

  rdt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .adc_start(adc_start));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (k >= 50) chk("pready", 32'(pready), 32'h0000_0001);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, r, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge pclk);
    chk("irq", 32'(irq), 32'(exp));
  endtask

  // Waits for one terminal-count pulse on the trigger output
  task automatic pulse;
    int k;
    k = 0;
    do @(negedge pclk); while (adc_start !== 1'b1 && ++k < 2000);
  endtask

  // Cycles between two successive terminal-count pulses; the first pulse
  // may still belong to the previous setting, so it is skipped
  task automatic gap(output int cnt);
    pulse();
    pulse();
    cnt = 0;
    do begin
      @(negedge pclk);
      cnt++;
    end while (adc_start !== 1'b1 && cnt < 2000);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    wrap_up();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0000_0000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    irq_chk(1'b0);
    rd_chk("reload_rst", RDT_ADDR_RELOAD, RDT_RST_RELOAD);
    rd_chk("live_rst", RDT_ADDR_LIVE, RDT_RST_LIVE);
    rd_chk("ctrl_rst", RDT_ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, RDT_ADDR_LIVE, 32'h0000_0005);
    chk("live_wr_err", 32'(e), 32'h0000_0001);
    apb(1'b0, RDT_ADDR_CLR, 32'h0000_0000);
    chk("clr_rd_err", 32'(e), 32'h0000_0001);
    apb(1'b0, 32'hffff_0320, 32'h0000_0000);
    chk("unmapped_err", 32'(e), 32'h0000_0001);
    rd_chk("live_kept", RDT_ADDR_LIVE, RDT_RST_LIVE);
    // Periodic down count, load 2, every prescale code
    apb(1'b1, RDT_ADDR_MASK, 32'h0000_0001);
    apb(1'b1, RDT_ADDR_RELOAD, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, RDT_ADDR_CTRL, 32'h0000_00c0 | 32'(i << 2));
      gap(n);
      chk("period", 32'(n), 32'(exp_gap[i]));
    end
    apb(1'b1, RDT_ADDR_CTRL, 32'h0000_0000);
    irq_chk(1'b1);
    apb(1'b1, RDT_ADDR_MASK, 32'h0000_0000);
    irq_chk(1'b0);
    apb(1'b1, RDT_ADDR_MASK, 32'h0000_0001);
    irq_chk(1'b1);
    apb(1'b1, RDT_ADDR_CLR, 32'h0000_005a);
    irq_chk(1'b0);
    rd_chk("status_clr", RDT_ADDR_STATUS, 32'h0000_0000);
    // Up count reaches full scale
    apb(1'b1, RDT_ADDR_DIR, 32'h0000_0001);
    apb(1'b1, RDT_ADDR_RELOAD, 32'h0000_fffd);
    apb(1'b1, RDT_ADDR_CTRL, 32'h0000_00c0);
    gap(n);
    chk("up_period", 32'(n), 32'h0000_0003);
    apb(1'b1, RDT_ADDR_CTRL, 32'h0000_0000);
    rd_chk("status_up", RDT_ADDR_STATUS, 32'h0000_0001);
    apb(1'b1, RDT_ADDR_STATUS, 32'h0000_0001);
    rd_chk("status_w1c", RDT_ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, RDT_ADDR_DIR, 32'h0000_0000);
    // Free-running wraps from zero, then holds when disabled
    apb(1'b1, RDT_ADDR_RELOAD, 32'h0000_0001);
    apb(1'b1, RDT_ADDR_CTRL, 32'h0000_0088);
    pulse();
    chk("wrap_event", 32'(adc_start), 32'h0000_0001);
    // Next tick, 256 cycles on, wraps to all ones for one prescale period
    repeat (300) @(negedge pclk);
    rd_chk("live_wrap", RDT_ADDR_LIVE, 32'h0000_ffff);
    apb(1'b1, RDT_ADDR_CTRL, 32'h0000_0008);
    repeat (600) @(negedge pclk);
    rd_chk("live_held", RDT_ADDR_LIVE, 32'h0000_ffff);
    // Time-of-day layout with borrow through every field
    apb(1'b1, RDT_ADDR_CTRL, 32'h0000_0028);
    apb(1'b1, RDT_ADDR_RELOAD, 32'h01c0_c080);
    rd_chk("tod_reload", RDT_ADDR_RELOAD, 32'h0100_0000);
    rd_chk("tod_live", RDT_ADDR_LIVE, 32'h0100_0000);
    apb(1'b1, RDT_ADDR_CTRL, 32'h0000_00a8);
    repeat (300) @(negedge pclk);
    rd_chk("tod_step", RDT_ADDR_LIVE, 32'h003b_3b7f);
    wrap_up();
  end
endmodule
`default_nettype wire
